// ### common/ppc_pkg.sv
// Constants and types for the pixel pipeline and cursor 1 configuration bank.
// Assumes one 200 MHz clock; every user of this package sits in that domain.
package ppc_pkg;

    // ****************************************************************
    // I/O ports and register indices
    // ****************************************************************
    localparam logic [15:0] PPC_IDX_PORT = 16'h03d6;
    localparam logic [15:0] PPC_DATA_PORT = 16'h03d7;
    localparam logic [7:0] PPC_IDX_DEPTH = 8'h81;
    localparam logic [7:0] PPC_IDX_GAMMA = 8'h82;
    localparam logic [7:0] PPC_IDX_CUR_CTL = 8'ha0;
    localparam logic [7:0] PPC_IDX_CUR_EXT = 8'ha1;
    localparam logic [7:0] PPC_RST_BYTE = 8'h00;

    // ****************************************************************
    // Field layouts
    // ****************************************************************
    localparam logic [7:0] PPC_DEPTH_MASK = 8'h1f;  // Bits 7-5 read zero
    localparam logic [7:0] PPC_GAMMA_MASK = 8'h0f;  // Bits 7-4 read zero
    localparam int PPC_DLY_OFF_BIT = 4;
    localparam int PPC_GFX_GAMMA_BIT = 3;
    localparam int PPC_VID_GAMMA_BIT = 2;
    localparam int PPC_SOG_BIT = 1;
    localparam int PPC_PED_BIT = 0;
    localparam int PPC_CUR_BLINK_BIT = 7;
    localparam int PPC_CUR_VSTR_BIT = 6;
    localparam int PPC_CUR_HSTR_BIT = 5;
    localparam int PPC_CUR_ORIG_BIT = 4;
    localparam int PPC_CUR_VEXT_BIT = 3;
    localparam int PPC_ENG_CRT_BIT = 0;
    localparam int PPC_ENG_FP_BIT = 1;
    localparam int PPC_HEXT_SHIFT = 2;              // Height is four lines per step

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int PPC_DLY_CYCLES = 2;              // Display enable and blank lag

    // ****************************************************************
    // Encodings
    // ****************************************************************
    typedef enum logic [3:0] {
        PPC_D_VGA = 4'h0, PPC_D_8 = 4'h2, PPC_D_555 = 4'h4,
        PPC_D_565 = 4'h5, PPC_D_24P = 4'h6, PPC_D_32 = 4'h7
    } ppc_depth_t;
    typedef enum logic [2:0] {
        PPC_C_OFF = 3'h0, PPC_C_32AX = 3'h1, PPC_C_128TC = 3'h2, PPC_C_128OT = 3'h3,
        PPC_C_64TT = 3'h4, PPC_C_64AX = 3'h5, PPC_C_64FC = 3'h6
    } ppc_cmode_t;
    localparam logic [5:0] PPC_BPP_VGA = 6'h00;
    localparam logic [5:0] PPC_BPP_8 = 6'h08;
    localparam logic [5:0] PPC_BPP_16 = 6'h10;
    localparam logic [5:0] PPC_BPP_24 = 6'h18;
    localparam logic [5:0] PPC_BPP_32 = 6'h20;
    localparam logic [7:0] PPC_SZ_32 = 8'h20;
    localparam logic [7:0] PPC_SZ_64 = 8'h40;
    localparam logic [7:0] PPC_SZ_128 = 8'h80;
    localparam logic [1:0] PPC_CBPP_1 = 2'h1;
    localparam logic [1:0] PPC_CBPP_2 = 2'h2;

endpackage : ppc_pkg

// ### hdl/ppc_pipe_cursor_cfg.sv
// Indexed configuration bank: pixel pipeline depth, gamma and sync options,
// and hardware cursor 1 control with its vertical extension.
// Assumes the I/O strobes, CRT timing, engine select and blink phase all come
// from logic on clk; only arst_n arrives asynchronously.
//
// Functional notes
// RQ1: Index port selects, data port reads or writes.
// RQ2: Unused upper bits of both pipeline registers read zero.
// RQ3: Delay bit clear delays enable and blank.
// RQ4: Delay only with VGA pipe, never flat panel.
// RQ5: Software clears delay for VGA, sets otherwise.
// RQ6: Depth codes 0000,0010,0100,0101 decoded.
// RQ7: Codes 0110,0111 decoded; others reserved.
// RQ8: Graphics gamma bit routes high depths through palette.
// RQ9: Video gamma bit routes video through palette.
// RQ10: Sync-on-green bit adds composite sync.
// RQ11: Pedestal bit enables blanking pedestal level.
// RQ12: Blink bit blinks cursor at external rate.
// RQ13: Stretch bits apply only on flat panel.
// RQ14: Origin bit picks border or active corner.
// RQ15: Extension bit takes height from extension register.
// RQ16: Cursor modes 000 to 011 decoded.
// RQ17: Cursor modes 100 to 110 decoded, 111 reserved.
// RQ18: Eight-bit extension register, resets to zero.
// RQ19: Extended height is four times value plus one.
// RQ20: Reserved codes hide cursor, harm nothing else.
`timescale 1ns/1ps
`default_nettype none
module ppc_pipe_cursor_cfg
    import ppc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // I/O port access
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // Display engine selection
    input wire logic [1:0] display_engine_select,
    // CRT timing in
    input wire logic crt_hsync_in,
    input wire logic crt_vsync_in,
    input wire logic crt_de_in,
    input wire logic crt_blank_in,
    // CRT timing out
    output logic crt_hsync_out,
    output logic crt_vsync_out,
    output logic crt_de_out,
    output logic crt_blank_out,
    // Pixel pipeline settings
    output logic [5:0] gfx_bpp,
    output logic gfx_rgb565,
    output logic depth_reserved,
    output logic gfx_palette_bypass,
    output logic video_via_palette,
    output logic sync_on_green,
    output logic blank_pedestal,
    // Cursor 1
    input wire logic blink_phase,
    output logic cursor_one_visible,
    output logic [2:0] cursor_one_mode,
    output logic [1:0] cursor_one_bpp,
    output logic [7:0] cursor_one_width,
    output logic [10:0] cursor_one_height,
    output logic cursor_one_vstretch,
    output logic cursor_one_hstretch,
    output logic cursor_one_origin_active
);

    // ****************************************************************
    // Reset release
    // ****************************************************************

    // Two-stage release; only the second stage is read by the design
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ****************************************************************
    // State
    // ****************************************************************

    // Everything the bank remembers, outputs included
    typedef struct packed {
        logic [7:0] index;         // Index port contents
        logic [7:0] depth;         // Pipeline depth and delay register
        logic [7:0] gamma;         // Gamma and sync register
        logic [7:0] cur_ctl;       // Cursor 1 control register
        logic [7:0] cur_ext;       // Cursor 1 height extension register
        logic [7:0] rdata;         // Read data holding register
        logic [3:0] crt;           // Hsync, vsync, enable, blank out
        logic [5:0] bpp;
        logic rgb565;
        logic d_rsvd;
        logic gfx_byp;
        logic vid_pal;
        logic sog;
        logic ped;
        logic cur_vis;
        logic [2:0] cur_mode;
        logic [1:0] cur_bpp;
        logic [7:0] cur_w;
        logic [10:0] cur_h;
        logic vstr;
        logic hstr;
        logic orig;
    } ppc_top_state_t;

    ppc_top_state_t st_q;
    ppc_top_state_t st_d;

    logic dly_apply;               // Delay path selected this cycle
    logic [1:0] dly_out;           // Enable and blank after the delay line
    logic fp_on;                   // Flat panel engine enabled
    logic [7:0] reg_rd;            // Addressed register contents
    logic idx_wr;                  // Write to the index port
    logic data_wr;                 // Write to the data port

    assign fp_on = display_engine_select[PPC_ENG_FP_BIT];
    assign idx_wr = io_wr && (io_addr == PPC_IDX_PORT);
    assign data_wr = io_wr && (io_addr == PPC_DATA_PORT);

    // ****************************************************************
    // Display enable and blank delay
    // ****************************************************************

    // Delay only when the CRT runs the VGA pipe and the panel is off
    assign dly_apply = !st_q.depth[PPC_DLY_OFF_BIT] // RQ3
        && display_engine_select[PPC_ENG_CRT_BIT] && !fp_on; // RQ4

    // Enable and blank run through the line all the time, so switching
    // the delay on mid-frame never shows stale levels
    ppc_sig_delay #(
        .W(2)
    ) u_dly (
        .clk(clk),
        .rst_n(rst_n),
        .din({crt_de_in, crt_blank_in}),
        .dout(dly_out)
    );

    // ****************************************************************
    // Register read selection
    // ****************************************************************

    // Unmapped indices read zero; reserved bits are never stored
    always_comb begin
        case (st_q.index) // RQ1
            PPC_IDX_DEPTH: reg_rd = st_q.depth & PPC_DEPTH_MASK; // RQ2
            PPC_IDX_GAMMA: reg_rd = st_q.gamma & PPC_GAMMA_MASK; // RQ2
            PPC_IDX_CUR_CTL: reg_rd = st_q.cur_ctl;
            PPC_IDX_CUR_EXT: reg_rd = st_q.cur_ext; // RQ18
            default: reg_rd = PPC_RST_BYTE;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************

    always_comb begin
        st_d = st_q;

        // Index port write, then data port write to the selected register
        if (idx_wr) begin
            st_d.index = io_wdata; // RQ1
        end
        if (data_wr) begin
            case (st_q.index) // RQ1
                PPC_IDX_DEPTH: st_d.depth = io_wdata & PPC_DEPTH_MASK; // RQ2
                PPC_IDX_GAMMA: st_d.gamma = io_wdata & PPC_GAMMA_MASK; // RQ2
                PPC_IDX_CUR_CTL: st_d.cur_ctl = io_wdata;
                PPC_IDX_CUR_EXT: st_d.cur_ext = io_wdata; // RQ18
                default: ;
            endcase
        end

        // Read data captured on the strobe and held until the next read
        if (io_rd) begin
            if (io_addr == PPC_IDX_PORT) begin
                st_d.rdata = st_q.index;
            end else if (io_addr == PPC_DATA_PORT) begin
                st_d.rdata = reg_rd; // RQ1
            end else begin
                st_d.rdata = PPC_RST_BYTE;
            end
        end

        // Syncs take one stage; enable and blank take that same stage
        // plus the line when delayed, keeping the lag against the syncs
        st_d.crt[3] = crt_hsync_in;
        st_d.crt[2] = crt_vsync_in;
        if (dly_apply) begin
            st_d.crt[1:0] = dly_out; // RQ3
        end else begin
            st_d.crt[1:0] = {crt_de_in, crt_blank_in}; // RQ4
        end

        // Colour depth; a reserved code falls back to VGA depth, flags
        // itself and leaves every other setting alone
        st_d.rgb565 = 1'b0;
        st_d.d_rsvd = 1'b0;
        case (st_q.depth[3:0])
            PPC_D_VGA: st_d.bpp = PPC_BPP_VGA; // RQ6
            PPC_D_8: st_d.bpp = PPC_BPP_8; // RQ6
            PPC_D_555: st_d.bpp = PPC_BPP_16; // RQ6
            PPC_D_565: begin
                st_d.bpp = PPC_BPP_16; // RQ6
                st_d.rgb565 = 1'b1;
            end
            PPC_D_24P: st_d.bpp = PPC_BPP_24; // RQ7
            PPC_D_32: st_d.bpp = PPC_BPP_32; // RQ7
            default: begin
                st_d.bpp = PPC_BPP_VGA; // RQ20
                st_d.d_rsvd = 1'b1; // RQ7
            end
        endcase

        // High depths skip the palette unless gamma is wanted; lower
        // depths are indexed and always need the palette
        st_d.gfx_byp = (st_d.bpp >= PPC_BPP_16)
            && !st_q.gamma[PPC_GFX_GAMMA_BIT]; // RQ8
        st_d.vid_pal = st_q.gamma[PPC_VID_GAMMA_BIT]; // RQ9
        st_d.sog = st_q.gamma[PPC_SOG_BIT]; // RQ10
        st_d.ped = st_q.gamma[PPC_PED_BIT]; // RQ11

        // Cursor mode: size and depth per code, reserved hides it
        st_d.cur_mode = st_q.cur_ctl[2:0];
        case (st_q.cur_ctl[2:0])
            PPC_C_32AX: begin
                st_d.cur_w = PPC_SZ_32; // RQ16
                st_d.cur_bpp = PPC_CBPP_2;
            end
            PPC_C_128TC, PPC_C_128OT: begin
                st_d.cur_w = PPC_SZ_128; // RQ16
                st_d.cur_bpp = PPC_CBPP_1;
            end
            PPC_C_64TT, PPC_C_64AX, PPC_C_64FC: begin
                st_d.cur_w = PPC_SZ_64; // RQ17
                st_d.cur_bpp = PPC_CBPP_2;
            end
            default: begin
                st_d.cur_w = 8'h00; // RQ16
                st_d.cur_bpp = 2'h0;
                st_d.cur_mode = PPC_C_OFF; // RQ20
            end
        endcase

        // Height from the extension register or from the mode's size
        if (st_q.cur_ctl[PPC_CUR_VEXT_BIT] && st_d.cur_w != 8'h00) begin
            st_d.cur_h = 11'(({3'h0, st_q.cur_ext} + 11'h001) << PPC_HEXT_SHIFT); // RQ15 RQ19
        end else begin
            st_d.cur_h = {3'h0, st_d.cur_w}; // RQ15
        end

        // Blink gates the cursor with the external blink phase
        st_d.cur_vis = (st_d.cur_mode != PPC_C_OFF)
            && (!st_q.cur_ctl[PPC_CUR_BLINK_BIT] || blink_phase); // RQ12

        // Stretching only takes effect while the panel engine runs
        st_d.vstr = st_q.cur_ctl[PPC_CUR_VSTR_BIT] && fp_on; // RQ13
        st_d.hstr = st_q.cur_ctl[PPC_CUR_HSTR_BIT] && fp_on; // RQ13
        st_d.orig = st_q.cur_ctl[PPC_CUR_ORIG_BIT]; // RQ14
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Every register and output clears to its documented default
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    assign io_rdata = st_q.rdata;
    assign crt_hsync_out = st_q.crt[3];
    assign crt_vsync_out = st_q.crt[2];
    assign crt_de_out = st_q.crt[1];
    assign crt_blank_out = st_q.crt[0];
    assign gfx_bpp = st_q.bpp;
    assign gfx_rgb565 = st_q.rgb565;
    assign depth_reserved = st_q.d_rsvd;
    assign gfx_palette_bypass = st_q.gfx_byp;
    assign video_via_palette = st_q.vid_pal;
    assign sync_on_green = st_q.sog;
    assign blank_pedestal = st_q.ped;
    assign cursor_one_visible = st_q.cur_vis;
    assign cursor_one_mode = st_q.cur_mode;
    assign cursor_one_bpp = st_q.cur_bpp;
    assign cursor_one_width = st_q.cur_w;
    assign cursor_one_height = st_q.cur_h;
    assign cursor_one_vstretch = st_q.vstr;
    assign cursor_one_hstretch = st_q.hstr;
    assign cursor_one_origin_active = st_q.orig;

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking ck @(posedge clk); endclocking
    default disable iff (!rst_n);

    idx_write_a: assert property ( // RQ1
        idx_wr |=> st_q.index == $past(io_wdata))
        else $error("Index port write was not captured");

    data_read_a: assert property ( // RQ1
        io_rd && io_addr == PPC_DATA_PORT && st_q.index == PPC_IDX_CUR_EXT
        |=> io_rdata == st_q.cur_ext)
        else $error("Data port read did not return the indexed register");

    rsvd_zero_a: assert property ( // RQ2
        io_rd && io_addr == PPC_DATA_PORT
        && (st_q.index == PPC_IDX_DEPTH || st_q.index == PPC_IDX_GAMMA)
        |=> io_rdata[7:4] == 4'h0 || ($past(st_q.index) == PPC_IDX_DEPTH
        && io_rdata[7:5] == 3'h0))
        else $error("Reserved pipeline bits read nonzero");

    crt_delay_a: assert property ( // RQ3
        dly_apply [*3] |=> crt_de_out == $past(crt_de_in, 3)
        && crt_blank_out == $past(crt_blank_in, 3))
        else $error("Enable and blank not delayed on the VGA pipe");

    crt_direct_a: assert property ( // RQ4
        (fp_on || st_q.depth[PPC_DLY_OFF_BIT])
        |=> crt_de_out == $past(crt_de_in) && crt_blank_out == $past(crt_blank_in))
        else $error("Enable and blank delayed when they must pass straight");

    depth_565_a: assert property ( // RQ6
        st_q.depth[3:0] == PPC_D_565 |=> gfx_bpp == PPC_BPP_16 && gfx_rgb565)
        else $error("Depth code 0101 not decoded as 16 bpp 5-6-5");

    depth_rsvd_a: assert property ( // RQ20
        st_q.depth[3] |=> depth_reserved && gfx_bpp == PPC_BPP_VGA && !gfx_palette_bypass)
        else $error("Reserved depth code not handled as harmless");

    gfx_bypass_a: assert property ( // RQ8
        st_q.depth[3:0] == PPC_D_32 && !st_q.gamma[PPC_GFX_GAMMA_BIT]
        |=> gfx_palette_bypass)
        else $error("32 bpp graphics did not bypass the palette");

    sog_ped_a: assert property ( // RQ10
        ##1 sync_on_green == $past(st_q.gamma[PPC_SOG_BIT])
        && blank_pedestal == $past(st_q.gamma[PPC_PED_BIT]))
        else $error("Sync on green or pedestal not following the register");

    cur_rsvd_a: assert property ( // RQ17
        st_q.cur_ctl[2:0] == 3'h7 |=> !cursor_one_visible && cursor_one_mode == PPC_C_OFF)
        else $error("Reserved cursor mode left the cursor showing");

    cur_blink_a: assert property ( // RQ12
        st_q.cur_ctl[PPC_CUR_BLINK_BIT] && !blink_phase |=> !cursor_one_visible)
        else $error("Blinking cursor visible in the dark phase");

    cur_height_a: assert property ( // RQ19
        st_q.cur_ctl[PPC_CUR_VEXT_BIT] && st_q.cur_ctl[2:0] == PPC_C_64AX
        |=> cursor_one_height == 11'(({3'h0, $past(st_q.cur_ext)} + 11'h001) * 11'h004))
        else $error("Extended cursor height is not four times value plus one");

    cur_stretch_a: assert property ( // RQ13
        !fp_on |=> !cursor_one_vstretch && !cursor_one_hstretch)
        else $error("Cursor stretched without the flat panel engine");

    delayed_c: cover property (dly_apply [*3] ##1 $changed(crt_de_out));
    ext_height_c: cover property (cursor_one_height > 11'h080);
    blink_c: cover property ($rose(cursor_one_visible) ##1 $fell(cursor_one_visible));
    rsvd_depth_c: cover property ($rose(depth_reserved));

endmodule : ppc_pipe_cursor_cfg
`default_nettype wire

// ### hdl/ppc_sig_delay.sv
// Fixed-length delay line for CRT display enable and blank.
// Assumes inputs come from logic on the same clock; reset is the synced copy.
`timescale 1ns/1ps
`default_nettype none
module ppc_sig_delay
    import ppc_pkg::*;
#(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    // All state of the line
    typedef struct packed {
        logic [PPC_DLY_CYCLES-1:0][W-1:0] pipe;
    } ppc_dly_state_t;

    ppc_dly_state_t st_q;
    ppc_dly_state_t st_d;

    // Shift one stage per clock
    always_comb begin
        st_d = st_q;
        st_d.pipe[0] = din;
        for (int i = 1; i < PPC_DLY_CYCLES; i++) begin
            st_d.pipe[i] = st_q.pipe[i-1];
        end
    end

    // Stages clear to inactive so nothing stale leaks after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.pipe[PPC_DLY_CYCLES-1];

    dly_line_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
        $past(rst_n, 2) |-> dout == $past(din, 2))
        else $error("Delay line output does not match input two cycles back");

endmodule : ppc_sig_delay
`default_nettype wire

// ### sim/pixel_pipe_cursor_config_test.sv
// Self-checking bench for the pipeline and cursor 1 configuration bank.
// Assumes ppc_pkg is compiled first; the bench drives every design port itself.
`timescale 1ns/1ps
`default_nettype none
module pixel_pipe_cursor_config_test;
    import ppc_pkg::*;
    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    logic [1:0] sel = 2'h1;       // Engine select, CRT on VGA pipe
    logic [3:0] crt_in = 4'h0;    // Hsync, vsync, enable, blank
    logic [3:0] crt_out;
    logic blink_phase = 1'b0;
    logic [5:0] bpp;
    logic rgb565, dres, byp, vid, sog, ped, vis, vstr, hstr, orig;
    logic [2:0] cmode;
    logic [1:0] cbpp;
    logic [7:0] cwid, rv;
    logic [10:0] chgt;
    int n_errors = 0;
    int total_checks = 0;

    ppc_pipe_cursor_cfg dut (.clk(clk), .arst_n(arst_n), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .display_engine_select(sel), .crt_hsync_in(crt_in[3]), .crt_vsync_in(crt_in[2]),
        .crt_de_in(crt_in[1]), .crt_blank_in(crt_in[0]), .crt_hsync_out(crt_out[3]),
        .crt_vsync_out(crt_out[2]), .crt_de_out(crt_out[1]), .crt_blank_out(crt_out[0]),
        .gfx_bpp(bpp), .gfx_rgb565(rgb565), .depth_reserved(dres),
        .gfx_palette_bypass(byp), .video_via_palette(vid), .sync_on_green(sog),
        .blank_pedestal(ped), .blink_phase(blink_phase), .cursor_one_visible(vis),
        .cursor_one_mode(cmode), .cursor_one_bpp(cbpp), .cursor_one_width(cwid),
        .cursor_one_height(chgt), .cursor_one_vstretch(vstr),
        .cursor_one_hstretch(hstr), .cursor_one_origin_active(orig));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Counts every compare; case inequality so an unknown never matches
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Index then data write; the extra edge lets the output stage catch up
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        @(negedge clk) {io_addr, io_wdata, io_wr} = {PPC_IDX_PORT, idx, 1'b1};
        @(negedge clk) {io_addr, io_wdata} = {PPC_DATA_PORT, val};
        @(negedge clk) io_wr = 1'b0;
        @(negedge clk);
    endtask : wr

    // Index write then data read; data is taken one edge after the strobe
    task automatic rd(input logic [7:0] idx, output logic [7:0] val);
        @(negedge clk) {io_addr, io_wdata, io_wr} = {PPC_IDX_PORT, idx, 1'b1};
        @(negedge clk) {io_addr, io_wr, io_rd} = {PPC_DATA_PORT, 1'b0, 1'b1};
        @(negedge clk) io_rd = 1'b0;
        val = io_rdata;
    endtask : rd

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Reset values of all four registers, an unmapped index reads zero
    task automatic t_reset();
        logic [7:0] idx [5] = '{8'h81, 8'h82, 8'ha0, 8'ha1, 8'h80};
        foreach (idx[i]) begin
            rd(idx[i], rv);
            check(rv, 16'h0000);
        end
        check({bpp, vis, cmode, byp, sog, ped}, 16'h0000);
        $display("reset test done");
    endtask : t_reset

    // Every depth code, written with the unused upper bits set
    task automatic t_depth();
        logic [5:0] eb;
        for (int c = 0; c < 16; c++) begin
            wr(8'h81, 8'he0 | 8'(c));
            rd(8'h81, rv);
            check(rv, 16'(c));
            eb = (c == 2) ? 6'h08 : (c == 4 || c == 5) ? 6'h10 : (c == 6) ? 6'h18 :
                 (c == 7) ? 6'h20 : 6'h00;
            check({bpp, rgb565, dres, byp}, {eb, c == 5, !(c inside {0, 2, [4:7]}),
                eb >= 6'h10});
        end
        $display("depth test done");
    endtask : t_depth

    // Each gamma and sync bit alone, at 16 bpp with the delay off as an
    // extended mode wants it, upper bits written high
    task automatic t_gamma();
        wr(8'h81, 8'h14);
        for (int b = 0; b < 4; b++) begin
            wr(8'h82, 8'hf0 | (8'h01 << b));
            rd(8'h82, rv);
            check(rv, 16'h0001 << b);
            check({byp, vid, sog, ped}, {b != 3, b == 2, b == 1, b == 0});
        end
        rd(8'h81, rv);
        check(rv, 16'h0014);
        $display("gamma test done");
    endtask : t_gamma

    // Every cursor mode, with and without vertical extension
    task automatic t_cursor();
        logic [7:0] w;
        logic [1:0] p;
        wr(8'ha1, 8'h0b);
        for (int m = 0; m < 16; m++) begin
            wr(8'ha0, 8'h10 | 8'(m));
            w = (m[2:0] == 1) ? 8'h20 : (m[2:0] inside {2, 3}) ? 8'h80 :
                (m[2:0] inside {[4:6]}) ? 8'h40 : 8'h00;
            p = (w == 8'h80) ? 2'h1 : (w != 8'h00) ? 2'h2 : 2'h0;
            check({vis, cmode, cbpp, orig}, {w != 0, (m[2:0] == 7) ? 3'h0 : m[2:0],
                p, 1'b1});
            check(cwid, w);
            check(chgt, (m[3] && w != 0) ? 16'd48 : 16'(w));
        end
        rd(8'ha1, rv);
        check(rv, 16'h000b);
        $display("cursor test done");
    endtask : t_cursor

    // Blink gating, then stretch only with the flat panel engine on
    task automatic t_blink_stretch();
        wr(8'ha0, 8'h81);
        for (int i = 0; i < 2; i++) begin
            @(negedge clk) blink_phase = i[0];
            repeat (2) @(negedge clk);
            check(vis, i[0]);
        end
        wr(8'ha0, 8'h61);
        for (int s = 0; s < 4; s++) begin
            @(negedge clk) sel = 2'(s);
            repeat (2) @(negedge clk);
            check({vstr, hstr, orig}, {{2{s[1]}}, 1'b0});
        end
        $display("blink and stretch test done");
    endtask : t_blink_stretch

    // Edge-to-edge lag of enable and blank against the syncs
    task automatic t_delay();
        logic [2:0] dl [4] = '{3'b001, 3'b101, 3'b011, 3'b000};
        logic [3:0] seen;
        int k;
        foreach (dl[i]) begin
            wr(8'h81, {3'h0, dl[i][2], 4'h0});
            sel = dl[i][1:0];
            repeat (4) @(negedge clk);
            crt_in = 4'hf;
            k = 0;
            do begin
                @(negedge clk) k++;
                if (k == 1) seen = crt_out;
                if (k == 10) begin
                    n_errors++;
                    results();
                end
            end while (crt_out[1] !== 1'b1);
            check(seen[3:2], 2'h3);
            check(16'(k), (dl[i] == 3'b001) ? 16'h0003 : 16'h0001);
            check(crt_out[0], 1'b1);
            crt_in = 4'h0;
        end
        $display("delay test done");
    endtask : t_delay

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_depth();
        t_gamma();
        t_cursor();
        t_blink_stretch();
        t_delay();
        results();
    end
endmodule : pixel_pipe_cursor_config_test
`default_nettype wire
